// ### boost_guard.sv
// Write guard key and boost-source configuration with output switch control
`timescale 1ns/1ps
`default_nettype none
module boost_guard #(
	parameter int RETRY_CYCLES = boost_guard_pkg::RETRY_WAIT_CYC,
	parameter bit LOW_POWER    = 1'b0
) (
	input  wire logic                      core_clk,
	input  wire logic                      nrst,
	input  wire boost_guard_pkg::reg_req_t req,
	input  wire logic [3:0]                mode_code,
	input  wire logic                      overcurrent,
	output logic [7:0]                     rdata_ff,
	output logic                           guard_unlocked_ff,
	output logic                           frs_enable_ff,
	output logic [11:0]                    source_limit_ma_ff,
	output logic                           source_limit_active_ff,
	output logic                           output_switch_on_ff
);
	import boost_guard_pkg::*;

	bank_state_t state_ff;
	bank_state_t nxt_state;
	logic        in_source;
	logic [11:0] decoded_ma;
	logic [11:0] linear_ma;
	logic        guard_wr;
	logic        boost_wr;
	logic [7:0]  guard_view;
	logic [7:0]  boost_view;
	logic        ocp_seen;
	logic        trip_retry;
	logic        trip_latch;
	logic        wait_done;

	// Mode and register strobe decode
	assign in_source = (mode_code == MODE_BOOST_SOURCE);
	assign guard_wr  = req.wr && (req.addr == GUARD_ADDR);
	assign boost_wr  = req.wr && (req.addr == BOOST_ADDR);

	// Read images; reserved bits read as zero
	assign guard_view = {6'h00, state_ff.key};
	assign boost_view = {state_ff.retry_en, state_ff.frs_en, 1'b0,
		state_ff.limit_code};

	// Overcurrent as seen after the two-flop synchroniser
	assign ocp_seen   = state_ff.ocp_sync;
	assign trip_retry = ocp_seen && state_ff.retry_en;
	assign trip_latch = ocp_seen && !state_ff.retry_en;
	assign wait_done  = (state_ff.wait_cnt <= 32'h1);

	// Linear limit decode before saturation and clamping
	assign linear_ma = 12'(LIMIT_BASE_MA
		+ 12'(state_ff.limit_code) * LIMIT_STEP_MA);

	// Saturating and clamped limit decode
	always_comb
	begin
		decoded_ma = 12'h000;
		if (LOW_POWER && (state_ff.limit_code >= LOWPWR_CLAMP_CODE))
		begin
			decoded_ma = LOWPWR_CLAMP_MA;
		end
		else if (state_ff.limit_code >= LIMIT_TOP_CODE)
		begin
			decoded_ma = LIMIT_TOP_MA;
		end
		else
		begin
			decoded_ma = linear_ma;
		end
	end

	// Next-state record
	always_comb
	begin
		nxt_state = state_ff;

		// Two-flop synchroniser for the overcurrent pin
		nxt_state.ocp_meta = overcurrent;
		nxt_state.ocp_sync = state_ff.ocp_meta;

		// Key write; reserved guard bits are dropped
		if (guard_wr)
		begin
			nxt_state.key = req.wdata[KEY_MSB:KEY_LSB];
		end

		// Boost configuration write; bit 5 is reserved
		if (boost_wr)
		begin
			nxt_state.retry_en   = req.wdata[RETRY_BIT];
			nxt_state.frs_en     = req.wdata[FRS_BIT];
			nxt_state.limit_code = req.wdata[LIMIT_MSB:LIMIT_LSB];
		end

		// Read data stands for one cycle after the strobe
		nxt_state.rdata = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				GUARD_ADDR:
				begin
					nxt_state.rdata = guard_view;
				end
				BOOST_ADDR:
				begin
					nxt_state.rdata = boost_view;
				end
				default:
				begin
					nxt_state.rdata = 8'h00;
				end
			endcase
		end

		// Levels registered straight to the outputs
		nxt_state.unlocked = (state_ff.key == KEY_UNLOCK);
		nxt_state.limit_active = in_source;
		nxt_state.limit_ma = in_source ? decoded_ma : 12'h000;

		// Output switch control
		case (state_ff.sw_state)
			SW_IDLE:
			begin
				if (in_source && !ocp_seen)
				begin
					nxt_state.sw_state = SW_ON;
				end
			end
			SW_ON:
			begin
				if (!in_source)
				begin
					nxt_state.sw_state = SW_IDLE;
				end
				else if (trip_retry)
				begin
					nxt_state.sw_state = SW_WAIT;
					nxt_state.wait_cnt = 32'(RETRY_CYCLES);
				end
				else if (trip_latch)
				begin
					nxt_state.sw_state = SW_LATCHED;
				end
			end
			SW_LATCHED:
			begin
				if (!in_source)
				begin
					nxt_state.sw_state = SW_IDLE;
				end
			end
			// Retry wait counts down, then the switch closes again
			SW_WAIT:
			begin
				if (!in_source)
				begin
					nxt_state.sw_state = SW_IDLE;
				end
				else if (wait_done)
				begin
					nxt_state.sw_state = SW_ON;
				end
				else
				begin
					nxt_state.wait_cnt = state_ff.wait_cnt - 32'h1;
				end
			end
			// Illegal code recovers to idle
			default:
			begin
				nxt_state.sw_state = SW_IDLE;
			end
		endcase
		nxt_state.switch_on = (nxt_state.sw_state == SW_ON);
	end

	// State record register
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff.key          <= KEY_RESET;
			state_ff.retry_en     <= 1'b0;
			state_ff.frs_en       <= 1'b0;
			state_ff.limit_code   <= LIMIT_RESET;
			state_ff.rdata        <= 8'h00;
			state_ff.unlocked     <= 1'b0;
			state_ff.limit_ma     <= 12'h000;
			state_ff.limit_active <= 1'b0;
			state_ff.switch_on    <= 1'b0;
			state_ff.sw_state     <= SW_IDLE;
			state_ff.wait_cnt     <= 32'h0;
			state_ff.ocp_meta     <= 1'b0;
			state_ff.ocp_sync     <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Outputs come straight from the state record
	assign rdata_ff               = state_ff.rdata;
	assign guard_unlocked_ff      = state_ff.unlocked;
	assign frs_enable_ff          = state_ff.frs_en;
	assign source_limit_ma_ff     = state_ff.limit_ma;
	assign source_limit_active_ff = state_ff.limit_active;
	assign output_switch_on_ff    = state_ff.switch_on;

endmodule : boost_guard
`default_nettype wire

// ### boost_guard_pkg.sv
// Constants, types and state record for the write guard and boost limit bank
package boost_guard_pkg;

	// Register offsets on the serial control bus
	localparam logic [7:0] GUARD_ADDR   = 8'h28;
	localparam logic [7:0] BOOST_ADDR   = 8'h29;

	// Field positions
	localparam int KEY_LSB       = 0;
	localparam int KEY_MSB       = 1;
	localparam int RETRY_BIT     = 7;
	localparam int FRS_BIT       = 6;
	localparam int LIMIT_LSB     = 0;
	localparam int LIMIT_MSB     = 4;

	// Reset values and unlock key
	localparam logic [1:0] KEY_RESET     = 2'h0;
	localparam logic [1:0] KEY_UNLOCK    = 2'h3;
	localparam logic [4:0] LIMIT_RESET   = 5'h00;

	// Mode code for boost-source operation
	localparam logic [3:0] MODE_BOOST_SOURCE = 4'hA;

	// Current limit decode, in mA
	localparam logic [11:0] LIMIT_BASE_MA   = 12'h1F4;
	localparam logic [11:0] LIMIT_STEP_MA   = 12'h064;
	localparam logic [4:0]  LIMIT_TOP_CODE  = 5'h1A;
	localparam logic [11:0] LIMIT_TOP_MA    = 12'hC1C;
	localparam logic [4:0]  LOWPWR_CLAMP_CODE = 5'h13;
	localparam logic [11:0] LOWPWR_CLAMP_MA = 12'h960;

	// Retry wait interval after an overcurrent trip
	localparam int CLK_MHZ          = 50;
	localparam int RETRY_WAIT_US    = 150;
	localparam int RETRY_WAIT_CYC   = RETRY_WAIT_US * CLK_MHZ;

	typedef enum logic [3:0] {
		SW_IDLE    = 4'h1,
		SW_ON      = 4'h2,
		SW_LATCHED = 4'h4,
		SW_WAIT    = 4'h8
	} switch_state_t;

	// Register bus request from the serial engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Whole state of the bank
	typedef struct packed {
		logic [1:0]    key;
		logic          retry_en;
		logic          frs_en;
		logic [4:0]    limit_code;
		logic [7:0]    rdata;
		logic          unlocked;
		logic [11:0]   limit_ma;
		logic          limit_active;
		logic          switch_on;
		switch_state_t sw_state;
		logic [31:0]   wait_cnt;
		logic          ocp_meta;
		logic          ocp_sync;
	} bank_state_t;

endpackage : boost_guard_pkg

// ### boost_guard_props.sv
// Assertion checker for the guard and boost bank
`timescale 1ns/1ps
`default_nettype none
module boost_guard_props (
	input wire logic	core_clk,
	input wire logic	nrst,
	input wire boost_guard_pkg::reg_req_t	req,
	input wire logic [3:0]	mode_code,
	input wire logic	overcurrent,
	input wire logic [7:0]	rdata_ff,
	input wire logic	guard_unlocked_ff,
	input wire logic	frs_enable_ff,
	input wire logic [11:0]	source_limit_ma_ff,
	input wire logic	source_limit_active_ff,
	input wire logic	output_switch_on_ff
);
	import boost_guard_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic bm = mode_code == MODE_BOOST_SOURCE;
	wire logic gw = req.wr && req.addr == GUARD_ADDR;
	wire logic [11:0] lim = source_limit_ma_ff;
	sequence s_key; gw && req.wdata[1:0] == KEY_UNLOCK; endsequence
	sequence s_out; (!bm) [*2]; endsequence
	property p_unl; s_key |-> ##2 guard_unlocked_ff; endproperty
	a_unl: assert property (p_unl) else $error("no unlock");
	property p_lck;
		gw && req.wdata[1:0] != KEY_UNLOCK |-> ##2 !guard_unlocked_ff;
	endproperty
	a_lck: assert property (p_lck) else $error("no lock");
	property p_frs;
		req.wr && req.addr == BOOST_ADDR
			|-> ##2 frs_enable_ff == $past(req.wdata[6], 2);
	endproperty
	a_frs: assert property (p_frs) else $error("frs");
	property p_idl;
		s_out |=> !source_limit_active_ff && lim == 12'h000;
	endproperty
	a_idl: assert property (p_idl) else $error("idle limit");
	property p_lim;
		lim != 12'h000 |-> lim inside {[LIMIT_BASE_MA:LIMIT_TOP_MA]}
			&& lim % LIMIT_STEP_MA == 12'h000;
	endproperty
	a_lim: assert property (p_lim) else $error("limit");
	property p_trp;
		$rose(overcurrent) && bm |-> ##[1:4] !output_switch_on_ff;
	endproperty
	a_trp: assert property (p_trp) else $error("trip");
	property p_krd;
		req.rd && req.addr == GUARD_ADDR |=> rdata_ff[7:2] == 6'h00
			&& (rdata_ff[1:0] == KEY_UNLOCK) == guard_unlocked_ff;
	endproperty
	a_krd: assert property (p_krd) else $error("key read");
	property p_rst;
		$rose(nrst) |-> !guard_unlocked_ff && !frs_enable_ff;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
endmodule : boost_guard_props
bind boost_guard boost_guard_props boost_guard_props_i (.core_clk, .nrst,
	.req, .mode_code, .overcurrent, .rdata_ff, .guard_unlocked_ff,
	.frs_enable_ff, .source_limit_ma_ff, .source_limit_active_ff,
	.output_switch_on_ff);
`default_nettype wire

// ### boost_guard_tb.sv
// Self-checking bench for the guard and boost bank
`timescale 1ns/1ps
`default_nettype none
module boost_guard_tb;
	import boost_guard_pkg::*;
	localparam int RC = 8;
	logic	core_clk = 1'b0;
	logic	nrst = 1'b0;
	logic	overcurrent = 1'b0;
	logic [3:0]	mode_code = 4'h0;
	logic [7:0]	rdata_ff;
	logic [7:0]	d;
	logic	guard_unlocked_ff;
	logic	frs_enable_ff;
	logic [11:0]	source_limit_ma_ff;
	logic [11:0]	lp_limit_ma;
	logic	source_limit_active_ff;
	logic	output_switch_on_ff;
	reg_req_t	req;
	int	error_cnt = 0;
	int	check_count = 0;
	always #10 core_clk = ~core_clk;
	host_model host_model_i (.core_clk, .rdata_ff, .req);
	boost_guard #(.RETRY_CYCLES(RC)) boost_guard_i (.core_clk, .nrst,
		.req, .mode_code, .overcurrent, .rdata_ff, .guard_unlocked_ff,
		.frs_enable_ff, .source_limit_ma_ff, .source_limit_active_ff,
		.output_switch_on_ff);
	boost_guard #(.RETRY_CYCLES(RC), .LOW_POWER(1'b1)) boost_guard_lp_i (
		.core_clk, .nrst, .req, .mode_code, .overcurrent, .rdata_ff(),
		.guard_unlocked_ff(), .frs_enable_ff(),
		.source_limit_ma_ff(lp_limit_ma), .source_limit_active_ff(),
		.output_switch_on_ff());
	task automatic chk(input string n, input logic [11:0] s, x);
		check_count++;
		if (s !== x)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	initial
	begin
		cyc(16);
		nrst = 1'b1;
		host_model_i.rd(BOOST_ADDR, d);
		chk("boost", {4'h0, d}, 12'h000);
		host_model_i.rd(GUARD_ADDR, d);
		chk("key0", {4'h0, d}, 12'h000);
		for (int k = 0; k < 4; k++)
		begin
			host_model_i.wr(GUARD_ADDR, 8'hFC | 8'(k));
			cyc(2);
			chk("unl", 12'(guard_unlocked_ff), 12'(k == 3));
		end
		host_model_i.rd(GUARD_ADDR, d);
		chk("key", {4'h0, d}, 12'h003);
		$display("guard test done");
		mode_code = MODE_BOOST_SOURCE;
		for (int c = 0; c < 32; c++)
		begin
			host_model_i.wr(BOOST_ADDR, 8'h60 | 8'(c));
			cyc(3);
			chk("lim", source_limit_ma_ff, c > 26 ? LIMIT_TOP_MA :
				LIMIT_BASE_MA + LIMIT_STEP_MA * 12'(c));
			chk("lp", lp_limit_ma, c > 18 ? LOWPWR_CLAMP_MA :
				LIMIT_BASE_MA + LIMIT_STEP_MA * 12'(c));
		end
		chk("act", 12'(source_limit_active_ff), 12'h001);
		host_model_i.rd(BOOST_ADDR, d);
		chk("cfg", {4'h0, d}, 12'h05F);
		chk("frs", 12'(frs_enable_ff), 12'h001);
		host_model_i.wr(8'h2A, 8'h00);
		cyc(2);
		chk("stay", 12'(guard_unlocked_ff), 12'h001);
		host_model_i.rd(8'h2A, d);
		chk("unmapped", {4'h0, d}, 12'h000);
		host_model_i.wr(BOOST_ADDR, 8'h1F);
		cyc(3);
		chk("sw", 12'(output_switch_on_ff), 12'h001);
		chk("frs off", 12'(frs_enable_ff), 12'h000);
		overcurrent = 1'b1;
		cyc(5);
		overcurrent = 1'b0;
		cyc(RC + 4);
		chk("latch", 12'(output_switch_on_ff), 12'h000);
		mode_code = 4'h0;
		cyc(3);
		chk("idle", source_limit_ma_ff, 12'h000);
		chk("inact", 12'(source_limit_active_ff), 12'h000);
		host_model_i.wr(BOOST_ADDR, 8'h9F);
		mode_code = MODE_BOOST_SOURCE;
		cyc(3);
		overcurrent = 1'b1;
		cyc(2);
		overcurrent = 1'b0;
		cyc(3);
		chk("trip", 12'(output_switch_on_ff), 12'h000);
		cyc(RC + 4);
		chk("retry", 12'(output_switch_on_ff), 12'h001);
		$display("boost test done");
		stop_test();
	end
	initial
	begin
		#100000;
		error_cnt++;
		stop_test();
	end
endmodule : boost_guard_tb
`default_nettype wire

// ### host_model.sv
// Host model issuing single-byte register cycles
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic	core_clk,
	input wire logic [7:0]	rdata_ff,
	output var boost_guard_pkg::reg_req_t	req
);
	import boost_guard_pkg::*;
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk) req = '{1'b1, 1'b0, a, v};
		@(negedge core_clk) req = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge core_clk) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge core_clk) v = rdata_ff;
		req = '0;
	endtask : rd
endmodule : host_model
`default_nettype wire
